// ### hdl/vpw_regs.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////
// overview
// this slice holds four configuration dwords: the product data control
// word, the product data word, the window translated base and the
// window setup word.  every register answers one cycle after the
// request, so software never sees a wait state.  the eeprom itself sits
// behind a simple request / done handshake; its serial timing lives in
// another block, which keeps this one free of long counters.
// hazards a user must know:
// - the setup word is caught from the straps once after reset; a strap
//   change later is not seen until the next reset.
// - a control write during a running eeprom cycle is dropped without any
//   indication, so software must poll the flag first.
// - the data word is shared between the host and the eeprom engine; a
//   host write during a running read is overwritten by the fetched data.
////////////////////////////////////////////////////////////////////////
module vpw_regs
  import vpw_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // configuration access
  input wire logic i_cfg_req,
  input wire vpw_cfg_req_s i_cfg,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // strap load of window setup
  input wire vpw_setup_s i_strap_loaded_attr,
  // eeprom engine
  output logic o_ee_req,
  output logic o_ee_wr,
  output logic [VPW_EE_AW-1:0] o_ee_addr,
  output logic [31:0] o_ee_wdata,
  input wire logic i_ee_done,
  input wire logic [31:0] i_ee_rdata,
  // upstream memory 0 translation
  input wire logic i_up_hit,
  input wire logic [31:0] i_up_addr,
  output logic [31:0] o_up_addr,
  output logic o_win_enable
);

  ////////////////////////////////////////////////////////////////////////
  // state
  vpw_state_e state_r, state_nxt;
  logic flag_r, flag_nxt;
  logic [VPW_ADDR_W-1:0] vaddr_r, vaddr_nxt;
  logic [31:0] data_r, data_nxt;
  logic [19:0] tbase_r, tbase_nxt;
  vpw_setup_s setup_r, setup_nxt;
  logic loaded_r, loaded_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ee_req_r, ee_req_nxt;
  logic ee_wr_r, ee_wr_nxt;
  logic [VPW_EE_AW-1:0] ee_addr_r, ee_addr_nxt;
  logic [31:0] up_addr_r, up_addr_nxt;
  // window enable flop; it never clears once out of reset
  logic en_r, en_nxt;
  logic [19:0] repl_mask;
  logic [31:0] ctrl_rd, tbase_rd, setup_rd;
  logic wr_hit_ctrl, wr_hit_data, wr_hit_tbase;

  ////////////////////////////////////////////////////////////////////////
  // decode and readback views
  always_comb begin
    wr_hit_ctrl = i_cfg_req && i_cfg.wr && (i_cfg.addr == VPW_OFS_CTRL);
    wr_hit_data = i_cfg_req && i_cfg.wr && (i_cfg.addr == VPW_OFS_DATA);
    wr_hit_tbase = i_cfg_req && i_cfg.wr && (i_cfg.addr == VPW_OFS_TBASE);
    // size mask bits
    // bit 31 has no mask bit; it is always part of the translated base
    repl_mask = {1'b1, setup_r.size_mask};
    ctrl_rd = {flag_r, 7'h00, vaddr_r, 2'h0, VPW_NEXT_PTR, VPW_CAP_ID};
    tbase_rd = {(tbase_r & repl_mask) | ~repl_mask, 12'h000};
    setup_rd = {1'b1, setup_r.size_mask, 8'h00, setup_r.prefetch,
                setup_r.width, 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration answer, one cycle after the request
  // the read data flop holds between reads so a slow host can still
  // pick it up after the ack pulse has gone; writes leave it untouched
  always_comb begin
    ack_nxt = i_cfg_req;
    rdata_nxt = rdata_r;
    if (i_cfg_req && !i_cfg.wr) begin
      case (i_cfg.addr)
        VPW_OFS_CTRL: rdata_nxt = ctrl_rd;
        VPW_OFS_DATA: rdata_nxt = data_r;
        VPW_OFS_TBASE: rdata_nxt = tbase_rd;
        VPW_OFS_SETUP: rdata_nxt = setup_rd;
        default: rdata_nxt = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // product data sequencer
  // the address byte and flag share byte lane 3/2; a busy cycle locks both
  // the eeprom address is formed at launch, not from the stored field,
  // so a flag write that also carries a new address uses the new one.
  // the request stays up until the edge after done, which lets the
  // engine sample address and direction at any point of the cycle.
  always_comb begin
    state_nxt = state_r;
    flag_nxt = flag_r;
    vaddr_nxt = vaddr_r;
    data_nxt = data_r;
    ee_req_nxt = ee_req_r;
    ee_wr_nxt = ee_wr_r;
    ee_addr_nxt = ee_addr_r;
    if (wr_hit_data) begin
      for (int b = 0; b < 4; b++) begin
        if (i_cfg.be[b]) begin
          data_nxt[8*b +: 8] = i_cfg.wdata[8*b +: 8];
        end
      end
    end
    case (state_r)
      VPW_IDLE: begin
        if (wr_hit_ctrl && i_cfg.be[2]) begin
          vaddr_nxt = i_cfg.wdata[VPW_ADDR_LSB +: VPW_ADDR_W];
        end
        if (wr_hit_ctrl && i_cfg.be[3]) begin
          flag_nxt = i_cfg.wdata[VPW_FLAG_BIT];
          ee_req_nxt = 1'b1;
          ee_wr_nxt = i_cfg.wdata[VPW_FLAG_BIT];
          ee_addr_nxt = VPW_EE_OFFSET + {1'b0,
            (i_cfg.be[2] ? i_cfg.wdata[VPW_ADDR_LSB +: VPW_ADDR_W]
                         : vaddr_r), 2'h0};
          state_nxt = i_cfg.wdata[VPW_FLAG_BIT] ? VPW_WR : VPW_RD;
        end
      end
      VPW_RD: begin
        if (i_ee_done) begin
          flag_nxt = 1'b1;
          data_nxt = i_ee_rdata;
          ee_req_nxt = 1'b0;
          state_nxt = VPW_IDLE;
        end
      end
      VPW_WR: begin
        if (i_ee_done) begin
          flag_nxt = 1'b0;
          ee_req_nxt = 1'b0;
          state_nxt = VPW_IDLE;
        end
      end
      default: begin
        state_nxt = VPW_IDLE;
        ee_req_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= VPW_IDLE;
      flag_r <= 1'b0;
      vaddr_r <= '0;
      data_r <= VPW_DATA_RST;
      ee_req_r <= 1'b0;
      ee_wr_r <= 1'b0;
      ee_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      flag_r <= flag_nxt;
      vaddr_r <= vaddr_nxt;
      data_r <= data_nxt;
      ee_req_r <= ee_req_nxt;
      ee_wr_r <= ee_wr_nxt;
      ee_addr_r <= ee_addr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // window registers and translation
  // straps are caught once, on the first edge after reset release
  // only mask-one bits of the base are stored; mask-zero bits stay at
  // their reset value so the translation never picks them up, and the
  // readback forces them high to show the window size to software.
  // bit 31 has no mask bit and is always part of the base.
  always_comb begin
    loaded_nxt = 1'b1;
    en_nxt = 1'b1;
    setup_nxt = setup_r;
    tbase_nxt = tbase_r;
    up_addr_nxt = up_addr_r;
    if (!loaded_r) begin
      setup_nxt = i_strap_loaded_attr;
    end
    // writable bits
    // byte lane 0 holds only read-only bits, so it is not looked at
    if (wr_hit_tbase) begin
      tbase_nxt = (tbase_r & ~repl_mask) |
                  ({i_cfg.be[3] ? i_cfg.wdata[31:24] : tbase_r[19:12],
                    i_cfg.be[2] ? i_cfg.wdata[23:16] : tbase_r[11:4],
                    i_cfg.be[1] ? i_cfg.wdata[15:12] : tbase_r[3:0]}
                   & repl_mask);
    end
    // masked replace
    // the translated address is registered, costing one cycle of latency
    // on the upstream path but keeping the output straight off a flop
    if (i_up_hit) begin
      up_addr_nxt = {(tbase_r & repl_mask) |
                     (i_up_addr[31:VPW_BASE_LSB] & ~repl_mask),
                     i_up_addr[VPW_BASE_LSB-1:0]};
    end else begin
      up_addr_nxt = i_up_addr;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      loaded_r <= 1'b0;
      en_r <= 1'b1;
      setup_r <= '{width: VPW_WIDTH_32, prefetch: 1'b0,
                   size_mask: VPW_MASK_RST};
      tbase_r <= VPW_TBASE_RST;
      up_addr_r <= 32'h0000_0000;
    end else begin
      loaded_r <= loaded_nxt;
      en_r <= en_nxt;
      setup_r <= setup_nxt;
      tbase_r <= tbase_nxt;
      up_addr_r <= up_addr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  // no output is decoded combinationally, so the host and the eeprom
  // engine always see clean values settled from the previous edge
  assign o_cfg_ack = ack_r;
  assign o_cfg_rdata = rdata_r;
  assign o_ee_req = ee_req_r;
  assign o_ee_wr = ee_wr_r;
  assign o_ee_addr = ee_addr_r;
  assign o_ee_wdata = data_r;
  assign o_up_addr = up_addr_r;
  assign o_win_enable = en_r;

endmodule
`default_nettype wire

// ### include/vpw_pkg.sv
`default_nettype none
package vpw_pkg;
  // register offsets (byte addresses on the configuration bus)
  localparam logic [7:0] VPW_OFS_CTRL = 8'hD8;
  localparam logic [7:0] VPW_OFS_DATA = 8'hDC;
  localparam logic [7:0] VPW_OFS_TBASE = 8'hE0;
  localparam logic [7:0] VPW_OFS_SETUP = 8'hE4;
  // capability header constants sharing the control dword
  localparam logic [7:0] VPW_CAP_ID = 8'h03;
  localparam logic [7:0] VPW_NEXT_PTR = 8'hF0;
  // control dword field positions
  localparam int VPW_FLAG_BIT = 31;
  localparam int VPW_ADDR_LSB = 18;
  localparam int VPW_ADDR_W = 6;
  // product data sits this far into the eeprom
  localparam logic [8:0] VPW_EE_OFFSET = 9'h040;
  localparam int VPW_EE_AW = 9;
  // window field positions
  localparam int VPW_BASE_LSB = 12;
  localparam int VPW_ENABLE_BIT = 31;
  // reset values
  localparam logic [31:0] VPW_DATA_RST = 32'h0000_0000;
  localparam logic [19:0] VPW_TBASE_RST = 20'h0_0000;
  localparam logic [18:0] VPW_MASK_RST = 19'h0_0000;
  localparam logic [1:0] VPW_WIDTH_32 = 2'h0;
  localparam logic [1:0] VPW_WIDTH_64 = 2'h1;

  // configuration request carrier
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } vpw_cfg_req_s;

  // strap-loaded window setup fields
  typedef struct packed {
    logic [1:0] width;
    logic prefetch;
    logic [18:0] size_mask;
  } vpw_setup_s;

  // eeprom sequencer states
  typedef enum logic [2:0] {
    VPW_IDLE = 3'b001,
    VPW_RD = 3'b010,
    VPW_WR = 3'b100
  } vpw_state_e;
endpackage
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  import vpw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 0, i_resetn = 0, i_cfg_req = 0, i_up_hit = 0;
  vpw_cfg_req_s i_cfg = '0;
  vpw_setup_s strap = '0;
  logic o_cfg_ack, o_ee_req, o_ee_wr, done, o_win_enable;
  logic [31:0] o_cfg_rdata, ee_wd, ee_rd, i_up_addr = 0, o_up_addr;
  logic [31:0] rd, w, e, base;
  logic [8:0] ee_a, ad;
  logic [19:0] m;
  logic [5:0] a6;
  logic [3:0] lat = 0, be;
  logic [7:0] ref_mem [512];
  int seed = 32'h54902d5f, bad_count = 0, tests_run = 0;
  initial forever #50 i_ref_clk = ~i_ref_clk;
  vpw_regs uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_cfg_req(i_cfg_req), .i_cfg(i_cfg), .o_cfg_ack(o_cfg_ack),
    .o_cfg_rdata(o_cfg_rdata), .i_strap_loaded_attr(strap),
    .o_ee_req(o_ee_req), .o_ee_wr(o_ee_wr), .o_ee_addr(ee_a),
    .o_ee_wdata(ee_wd), .i_ee_done(done), .i_ee_rdata(ee_rd),
    .i_up_hit(i_up_hit), .i_up_addr(i_up_addr), .o_up_addr(o_up_addr),
    .o_win_enable(o_win_enable));
  vpw_ee_model u_ee (.i_ref_clk(i_ref_clk), .i_ee_req(o_ee_req),
    .i_ee_wr(o_ee_wr), .i_ee_addr(ee_a), .i_ee_wdata(ee_wd), .i_lat(lat),
    .o_ee_done(done), .o_ee_rdata(ee_rd));
  // one access, entered and left at a falling edge
  task automatic cfg(input logic wr, input logic [7:0] a,
    input logic [3:0] b, input logic [31:0] d);
    i_cfg_req = 1'b1;
    i_cfg = '{wr, a, b, d};
    @(negedge i_ref_clk);
    i_cfg_req = 1'b0;
    `CHK(o_cfg_ack, 1'b1)
    rd = o_cfg_rdata;
    @(negedge i_ref_clk);
  endtask
  // bounded poll of the operation flag
  task automatic poll(input logic f);
    cfg(0, VPW_OFS_CTRL, 4'hF, 0);
    for (int k = 0; k < 40 && rd[31] !== f; k++) cfg(0, VPW_OFS_CTRL, 4'hF, 0);
    `CHK(rd[31], f)
  endtask
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    print_verdict();
  end
  initial begin
    for (int i = 0; i < 512; i++) ref_mem[i] = 8'(i) ^ 8'h5A;
    strap = 22'($random(seed));
    m = {1'b1, strap.size_mask};
    repeat (3) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    `CHK(o_win_enable, 1'b1)
    cfg(1, VPW_OFS_SETUP, 4'hF, 0);
    cfg(0, VPW_OFS_SETUP, 4'hF, 0);
    `CHK(rd, {1'b1, strap.size_mask, 8'h00, strap.prefetch, strap.width, 1'b0})
    cfg(0, VPW_OFS_TBASE, 4'hF, 0);
    `CHK(rd[30:0], {~strap.size_mask, 12'h000})
    base = $random(seed);
    cfg(1, VPW_OFS_TBASE, 4'hF, base);
    cfg(0, VPW_OFS_TBASE, 4'hF, 0);
    w = {base[31], (base[30:12] & strap.size_mask) | ~strap.size_mask, 12'h0};
    `CHK(rd, w)
    cfg(0, 8'hC0, 4'hF, 0);
    `CHK(rd, 32'h0)
    repeat (8) begin
      i_up_hit = 1'($random(seed));
      i_up_addr = $random(seed);
      @(negedge i_ref_clk);
      w = {(base[31:12] & m) | (i_up_addr[31:12] & ~m), i_up_addr[11:0]};
      `CHK(o_up_addr, i_up_hit ? w : i_up_addr)
    end
    for (int n = 0; n < 4; n++) begin
      if (n % 2 == 0) a6 = 6'($random(seed));
      lat = 4'h8 | 4'($random(seed));
      ad = VPW_EE_OFFSET + {1'b0, a6, 2'h0};
      cfg(1, VPW_OFS_CTRL, 4'hC, {8'h00, a6, 18'h0});
      cfg(1, VPW_OFS_CTRL, 4'hC, {8'h80, ~a6, 18'h0});
      cfg(0, VPW_OFS_CTRL, 4'hF, 0);
      `CHK({rd[31], rd[23:18], rd[15:0]}, {1'b0, a6, 16'hF003})
      poll(1'b1);
      cfg(0, VPW_OFS_DATA, 4'hF, 0);
      e = {ref_mem[ad+3], ref_mem[ad+2], ref_mem[ad+1], ref_mem[ad]};
      `CHK(rd, e)
      w = $random(seed);
      be = 4'($random(seed));
      cfg(1, VPW_OFS_DATA, be, w);
      for (int b = 0; b < 4; b++) if (be[b]) e[8*b +: 8] = w[8*b +: 8];
      cfg(0, VPW_OFS_DATA, 4'hF, 0);
      `CHK(rd, e)
      cfg(1, VPW_OFS_CTRL, 4'hC, {8'h80, a6, 18'h0});
      cfg(0, VPW_OFS_CTRL, 4'hF, 0);
      `CHK(rd[31], 1'b1)
      poll(1'b0);
      for (int b = 0; b < 4; b++) ref_mem[ad + b] = e[8*b +: 8];
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// ### tb/vpw_ee_model.sv
`default_nettype none
module vpw_ee_model
  import vpw_pkg::*;
(
  // eeprom engine side
  input wire logic i_ref_clk,
  input wire logic i_ee_req,
  input wire logic i_ee_wr,
  input wire logic [VPW_EE_AW-1:0] i_ee_addr,
  input wire logic [31:0] i_ee_wdata,
  input wire logic [3:0] i_lat,
  output logic o_ee_done,
  output logic [31:0] o_ee_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [512];
  logic busy = 1'b0;
  int cnt = 0;
  initial begin
    o_ee_done = 1'b0;
    o_ee_rdata = '0;
    for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  // idle data toggles so a stale value is never mistaken for an answer
  always @(negedge i_ref_clk) begin
    o_ee_rdata <= ~o_ee_rdata;
    if (o_ee_done) o_ee_done <= 1'b0;
    else if (busy && cnt == 0) begin
      busy <= 1'b0;
      o_ee_done <= 1'b1;
      for (int b = 0; b < 4; b++) begin
        if (i_ee_wr) mem[i_ee_addr + b] <= i_ee_wdata[8*b +: 8];
        else o_ee_rdata[8*b +: 8] <= mem[i_ee_addr + b];
      end
    end else if (busy) cnt <= cnt - 1;
    else if (i_ee_req) begin
      busy <= 1'b1;
      cnt <= i_lat;
    end
  end
endmodule
`default_nettype wire

// ### tb/vpw_regs_sva.sv
`default_nettype none
module vpw_regs_sva
  import vpw_pkg::*;
(
  // watched ports
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_cfg_req,
  input wire vpw_cfg_req_s i_cfg,
  input wire logic o_cfg_ack,
  input wire logic [31:0] o_cfg_rdata,
  input wire vpw_setup_s i_strap_loaded_attr,
  input wire logic o_ee_req,
  input wire logic o_ee_wr,
  input wire logic [VPW_EE_AW-1:0] o_ee_addr,
  input wire logic i_ee_done,
  input wire logic i_up_hit,
  input wire logic [31:0] i_up_addr,
  input wire logic [31:0] o_up_addr,
  input wire logic o_win_enable
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire logic go;
  wire logic rd;
  // idle launch of an eeprom op, and plain reads
  assign go = i_cfg_req && i_cfg.wr && i_cfg.be[3] &&
    i_cfg.addr == VPW_OFS_CTRL && !o_ee_req;
  assign rd = i_cfg_req && !i_cfg.wr;
  a_ack_next: assert property (i_cfg_req |=> o_cfg_ack)
    else $error("ack missing");
  a_read_go: assert property (go && !i_cfg.wdata[31] |=> o_ee_req && !o_ee_wr)
    else $error("read not started");
  a_write_go: assert property (go && i_cfg.wdata[31] |=> o_ee_req && o_ee_wr)
    else $error("write not started");
  a_ee_addr: assert property (go && i_cfg.be[2] |=> o_ee_addr ==
    VPW_EE_OFFSET + {1'b0, $past(i_cfg.wdata[23:18]), 2'h0})
    else $error("eeprom address wrong");
  a_busy_hold: assert property (o_ee_req && !i_ee_done |=> o_ee_req &&
    $stable(o_ee_addr) && $stable(o_ee_wr))
    else $error("eeprom op disturbed");
  a_done_drop: assert property (i_ee_done |=> !o_ee_req)
    else $error("request not released");
  a_setup_val: assert property (rd && i_cfg.addr == VPW_OFS_SETUP |=>
    o_cfg_rdata[30:0] == {i_strap_loaded_attr.size_mask, 8'h00,
    i_strap_loaded_attr.prefetch, i_strap_loaded_attr.width, 1'b0})
    else $error("setup readback wrong");
  a_base_low: assert property (rd && i_cfg.addr == VPW_OFS_TBASE |=>
    o_cfg_rdata[11:0] == 12'h000)
    else $error("base low bits set");
  a_pass_thru: assert property (!i_up_hit |=> o_up_addr == $past(i_up_addr))
    else $error("miss altered address");
  a_kept_bits: assert property (i_up_hit |=> ((o_up_addr ^ $past(i_up_addr))
    & {1'b0, ~i_strap_loaded_attr.size_mask, 12'hFFF}) == 32'h0)
    else $error("fixed bits replaced");
  a_enable_on: assert property (o_win_enable |=> o_win_enable)
    else $error("enable dropped");
endmodule
bind vpw_regs vpw_regs_sva u_sva (.*);
`default_nettype wire
